// >>> logic/dac_pd_ctrl.sv
`timescale 1ns/100ps
`include "dac_pd_cfg.svh"
// Function
// RQ1: Reset clears holding and output registers
// RQ2: Outputs stay zero until data written
// RQ3: Nibbles 1101/1110/1111 select termination
// RQ4: Low eight bits select channels
// RQ5: Powered-down channel core and buffer off
// RQ6: Bias off only when all down
// RQ7: Power-down keeps register contents
// RQ8: Serial interface works during power-down
// RQ9: Recovery resumes with retained value
// RQ10: Recovery completes within 20 microseconds
// RQ11: Host idles link for lowest power
// RQ12: Channel write frames per mode
// RQ13: Output update ends power-down
module dac_pd_ctrl
  import dac_pd_pkg::*;
#(
  parameter int RECOVER_CYCLES = `RECOVER_CYC
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // Serial link pins
  input wire logic SCLK,
  input wire logic SYNC_N,
  input wire logic DIN,
  // Channel state
  output logic [`NUM_CH*`CODE_BITS-1:0] HOLD_CODES,
  output logic [`NUM_CH*`CODE_BITS-1:0] OUT_CODES,
  output logic [`NUM_CH-1:0] CH_POWER_ON,
  output logic [`NUM_CH*2-1:0] CH_TERM,
  output logic [`NUM_CH-1:0] CH_RAMPING,
  output logic BIAS_EN,
  output logic DATA_VALID
);
  // The recovery counter is 16 bits wide
  if (RECOVER_CYCLES < 1 || RECOVER_CYCLES > 65535) begin : gen_bad_recover
    $error("RECOVER_CYCLES out of range");
  end

  localparam int NC = `NUM_CH;
  localparam int CB = `CODE_BITS;

  // Two-flop synchronisers; the second stage is read, and the third stage too for SCLK edge detection
  logic [2:0] s1_q, s2_q, s3_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s1_q <= 3'b010;
      s2_q <= 3'b010;
      s3_q <= 3'b010;
    end else if (CE) begin
      s1_q <= {DIN, SYNC_N, SCLK};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire sclk_s = s2_q[0];
  wire sync_s = s2_q[1];
  wire din_s = s2_q[2];
  // Data latched on falling SCLK edge while frame select is low
  wire fall = s3_q[0] & ~sclk_s;

  logic [`FRAME_BITS-1:0] sh_q;
  logic [4:0] cnt_q;
  logic frame_v_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      frame_v_q <= 1'b0;
    end else if (CE) begin
      frame_v_q <= 1'b0;
      if (sync_s) begin
        cnt_q <= 5'h00;
      end else if (fall) begin
        sh_q <= {sh_q[`FRAME_BITS-2:0], din_s};
        // RQ8: shifting is independent of power state
        if (cnt_q == 5'(`FRAME_BITS - 1)) begin
          frame_v_q <= 1'b1;
          cnt_q <= 5'h00;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end
  // Completed frame is the shift register one cycle after the last bit
  wire [3:0] command_nibble = sh_q[15:12];
  wire [CB-1:0] fcode = sh_q[CB-1:0];
  wire [2:0] fch = sh_q[14:12];

  function automatic logic [NC-1:0] onehot(input logic [2:0] idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction

  wmode_t mode_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_q <= MODE_WR_REG;
    end else if (CE && frame_v_q) begin
      if (command_nibble == `CMD_WR_REG) mode_q <= MODE_WR_REG;
      else if (command_nibble == `CMD_WR_THRU) mode_q <= MODE_WR_THRU;
    end
  end

  // Per-frame decode: which holding registers load, which outputs update
  logic [NC-1:0] hold_wr, out_upd, pd_sel;
  logic [CB-1:0] wr_code;
  term_t pd_term;
  always_comb begin
    hold_wr = '0;
    out_upd = '0;
    pd_sel = '0;
    wr_code = fcode;
    pd_term = TERM_ACTIVE;
    if (frame_v_q) begin
      if (!command_nibble[3]) begin
        hold_wr = onehot(fch); // RQ12
        if (mode_q == MODE_WR_THRU) out_upd = onehot(fch); // RQ12
      end else begin
        case (command_nibble)
          `CMD_UPD: out_upd = sh_q[NC-1:0];
          `CMD_CH1: begin
            hold_wr = onehot(3'd0);
            out_upd = '1;
          end
          `CMD_BCAST: begin
            hold_wr = '1;
            out_upd = '1;
          end
          // RQ3 RQ4: bits 11..8 ignored, any channel mask allowed
          `CMD_PD_HIZ: begin
            pd_sel = sh_q[NC-1:0];
            pd_term = TERM_HIZ;
          end
          `CMD_PD_100K: begin
            pd_sel = sh_q[NC-1:0];
            pd_term = TERM_100K;
          end
          `CMD_PD_2K5: begin
            pd_sel = sh_q[NC-1:0];
            pd_term = TERM_2K5;
          end
          default: ;
        endcase
      end
    end
  end

  // Holding and output registers: never touched by power-down, only by writes
  logic [CB-1:0] hold_q [NC];
  logic [CB-1:0] out_q [NC];
  logic [1:0] term_q [NC];
  logic [15:0] rcnt_q [NC];
  logic valid_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NC; i++) begin
        hold_q[i] <= `CODE_RESET; // RQ1
        out_q[i] <= `CODE_RESET; // RQ1
      end
    end else if (CE) begin
      for (int i = 0; i < NC; i++) begin
        // RQ7 RQ8 RQ9: powered-down channels still load, never cleared
        if (hold_wr[i]) hold_q[i] <= wr_code;
        if (out_upd[i]) out_q[i] <= hold_wr[i] ? wr_code : hold_q[i];
      end
    end
  end

  // RQ2: outputs read as zero code until a first output update
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) valid_q <= 1'b0;
    else if (CE && |out_upd) valid_q <= 1'b1; // RQ2
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NC; i++) begin
        term_q[i] <= TERM_ACTIVE;
        rcnt_q[i] <= 16'h0000;
      end
    end else if (CE) begin
      for (int i = 0; i < NC; i++) begin
        if (pd_sel[i]) begin
          term_q[i] <= pd_term; // RQ3
          rcnt_q[i] <= 16'h0000;
        end else if (out_upd[i] && term_q[i] != TERM_ACTIVE) begin
          term_q[i] <= TERM_ACTIVE; // RQ13
          rcnt_q[i] <= 16'(RECOVER_CYCLES); // RQ10
        end else if (rcnt_q[i] != 16'h0000) begin
          rcnt_q[i] <= rcnt_q[i] - 16'h0001; // RQ10
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NC; i++) begin
      HOLD_CODES[i*CB +: CB] = hold_q[i];
      OUT_CODES[i*CB +: CB] = valid_q ? out_q[i] : `CODE_RESET;
      CH_POWER_ON[i] = (term_q[i] == TERM_ACTIVE); // RQ5
      CH_TERM[i*2 +: 2] = term_q[i];
      CH_RAMPING[i] = (rcnt_q[i] != 16'h0000);
    end
  end
  assign BIAS_EN = |CH_POWER_ON; // RQ6
  assign DATA_VALID = valid_q;

  // Independent count of ramp cycles on channel one, bounds the recovery time
  logic [15:0] ramp0_cyc_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ramp0_cyc_q <= 16'h0000;
    end else if (CE) begin
      if (!CH_RAMPING[0]) ramp0_cyc_q <= 16'h0000;
      else if (ramp0_cyc_q != 16'hFFFF) ramp0_cyc_q <= ramp0_cyc_q + 16'h0001;
    end
  end

  sequence pd_frame_s(int k);
    CE && frame_v_q && command_nibble[3:2] == 2'b11 && command_nibble != `CMD_BCAST && sh_q[k];
  endsequence

  pd_ch0_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ3
    pd_frame_s(0) |=> !CH_POWER_ON[0]) else $error("ch0 not powered down");
  ramp_bound_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ10
    CE && CH_RAMPING[0] |-> ramp0_cyc_q < 16'(RECOVER_CYCLES)) else $error("ramp over budget");
  pd_keep_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ7
    CE && |pd_sel && !(|hold_wr) |=> $stable(HOLD_CODES)) else $error("pd changed reg");
  bias_all_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ6
    BIAS_EN == (CH_POWER_ON != 8'h00)) else $error("bias mismatch");
  zero_out_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ2
    !DATA_VALID |-> OUT_CODES == '0) else $error("output not zero");
  recov_time_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ10
    $rose(CH_RAMPING[0]) |-> rcnt_q[0] <= 16'(RECOVER_CYCLES)) else $error("ramp too long");
  wake_up_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ13
    CE && out_upd[0] && !pd_sel[0] |=> CH_POWER_ON[0]) else $error("no wake");
  bcast_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ12
    CE && frame_v_q && command_nibble == `CMD_BCAST |=> hold_q[7] == $past(fcode))
    else $error("broadcast lost");
  mask_a: assert property (@(posedge CLK) disable iff (!NRST) // RQ4
    CE && |pd_sel |-> pd_sel == sh_q[7:0]) else $error("mask wrong");
endmodule

// >>> pkg/dac_pd_cfg.svh
`ifndef DAC_PD_CFG_SVH
`define DAC_PD_CFG_SVH
`define FRAME_BITS 16
`define CODE_BITS 12
`define NUM_CH 8
`define CMD_WR_REG 4'h8
`define CMD_WR_THRU 4'h9
`define CMD_UPD 4'hA
`define CMD_CH1 4'hB
`define CMD_BCAST 4'hC
`define CMD_PD_HIZ 4'hD
`define CMD_PD_100K 4'hE
`define CMD_PD_2K5 4'hF
`define CODE_RESET 12'h000
`define CLK_NS 5
`define RECOVER_US 20
`define RECOVER_CYC ((`RECOVER_US * 1000) / `CLK_NS)
`endif

// >>> pkg/dac_pd_pkg.sv
package dac_pd_pkg;
  typedef enum logic [1:0] {
    TERM_ACTIVE = 2'b00,
    TERM_HIZ = 2'b01,
    TERM_100K = 2'b10,
    TERM_2K5 = 2'b11
  } term_t;
  typedef enum logic [0:0] {
    MODE_WR_REG = 1'b0,
    MODE_WR_THRU = 1'b1
  } wmode_t;
endpackage

// >>> tb/dac_host_model.sv
`timescale 1ns/100ps
module dac_host_model (
  // Clock
  input wire logic clk,
  // Serial link
  output logic sclk,
  output logic sync_n,
  output logic din
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // Halves of 6 and 7 cycles: 65 ns link period, the nearest the 5 ns grid allows to 64 ns
  task automatic send(input logic [15:0] frame);
    @(posedge clk);
    sync_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (6) @(posedge clk);
      din <= frame[i];
      sclk <= 1'b1;
      repeat (7) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (7) @(posedge clk);
    // Link parked between frames, clock stopped
    sync_n <= 1'b1;
    din <= 1'b0;
  endtask
endmodule

// >>> tb/dac_pd_ctrl_tb.sv
`timescale 1ns/100ps
module dac_pd_ctrl_tb;
  import dac_pd_pkg::*;
  logic clk, nrst, sclk, sync_n, din, bias, valid;
  logic [95:0] hold, outc;
  logic [7:0] pwr, ramp;
  logic [15:0] term;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  dac_pd_ctrl #(.RECOVER_CYCLES(20)) i_dac_pd_ctrl (.CLK(clk), .NRST(nrst), .CE(1'b1),
    .SCLK(sclk), .SYNC_N(sync_n), .DIN(din), .HOLD_CODES(hold), .OUT_CODES(outc),
    .CH_POWER_ON(pwr), .CH_TERM(term), .CH_RAMPING(ramp), .BIAS_EN(bias), .DATA_VALID(valid));
  dac_host_model i_dac_host_model (.clk(clk), .sclk(sclk), .sync_n(sync_n), .din(din));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Outputs settle 4 cycles after the last falling SCLK edge
  task automatic frame(input logic [15:0] f);
    i_dac_host_model.send(f);
    repeat (6) @(posedge clk);
    // Sample away from the launching edge
    @(negedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(hold, '0);
    check(outc, '0);
    check({pwr, bias, valid}, {8'hFF, 1'b1, 1'b0});
    $display("test reset done");
    frame(16'h8000);
    frame(16'h2123);
    check(hold[35:24], 12'h0123);
    check(outc, '0);
    frame(16'h9000);
    frame(16'h1ABC);
    check({outc[23:12], valid}, {12'h0ABC, 1'b1});
    $display("test modes done");
    // Ignored bits 11..8 set on purpose
    frame(16'hDF05);
    check({pwr, term}, {8'hFA, 16'h0011});
    frame(16'hE002);
    check({pwr, term, bias}, {8'hF8, 16'h0019, 1'b1});
    frame(16'hF0F8);
    check({pwr, term, bias}, {8'h00, 16'hFFD9, 1'b0});
    check(hold[35:0], 36'h1_23AB_C000);
    $display("test power down done");
    frame(16'h8000);
    frame(16'h2456);
    check({hold[35:24], pwr}, {12'h0456, 8'h00});
    frame(16'hA004);
    check({pwr, ramp, bias}, {8'h04, 8'h04, 1'b1});
    check(outc[35:24], 12'h0456);
    repeat (20) @(posedge clk);
    @(negedge clk);
    check({ramp, term[5:4]}, {8'h00, TERM_ACTIVE});
    frame(16'hB777);
    check({pwr, outc[23:0]}, {8'hFF, 24'hAB_C777});
    frame(16'hC5A5);
    check(outc, {8{12'h05A5}});
    $display("test recovery done");
    final_report();
  end
endmodule
